//--- hdl/fas_defs.svh
// Constants for the field-adjust settings bank.
// Assumes inclusion by bare name from design and bench files.
`ifndef FAS_DEFS_SVH
`define FAS_DEFS_SVH

// ----------------------------------------
// Register numbers
// ----------------------------------------
`define FAS_REG_FIRST        7'h33
`define FAS_REG_LAST         7'h63
`define FAS_STD_FIRST        7'h41
`define FAS_STD_LAST         7'h60
`define FAS_HALL_DWELL       7'h41
`define FAS_CAR_DWELL        7'h42
`define FAS_SHORT_DWELL      7'h43
`define FAS_RUN_SHUTDOWN     7'h44
`define FAS_NUDGING          7'h45
`define FAS_EYE_CUTOUT       7'h46
`define FAS_STUCK_BUTTON     7'h47
`define FAS_LANDING_COUNT    7'h4c
`define FAS_MAIN_FIRE        7'h4d
`define FAS_ALT_FIRE         7'h4e
`define FAS_ALT_HOME         7'h55

// ----------------------------------------
// Factory defaults
// ----------------------------------------
`define FAS_DEF_HALL_DWELL   16'h0032
`define FAS_DEF_CAR_DWELL    16'h0032
`define FAS_DEF_SHORT_DWELL  16'h000a
`define FAS_DEF_RUN_SHUTDOWN 16'h00fa
`define FAS_DEF_NUDGING      16'h0019
`define FAS_DEF_EYE_CUTOUT   16'h0014
`define FAS_DEF_STUCK_BUTTON 16'h001e
`define FAS_DEF_LANDINGS     16'h0008
`define FAS_DEF_MAIN_FIRE    16'h0001
`define FAS_DEF_ALT_FIRE     16'h0002
`define FAS_DEF_ALT_HOME     16'h0001
`define FAS_DEF_OTHER        16'h0000

// ----------------------------------------
// Timing
// ----------------------------------------
`define FAS_CLK_MHZ          250
`define FAS_TENTH_NS         100000000
`define FAS_CLK_NS           4
`define FAS_TENTH_CYCLES     (`FAS_TENTH_NS / `FAS_CLK_NS)
`define FAS_TENTHS_PER_SEC   16'h000a
`define FAS_SHORT_CAR_DWELL  16'h0014

`endif

//--- hdl/fas_pkg.sv
// Types for the field-adjust settings bank.
// Assumes fas_defs.svh is available.
package fas_pkg;

  typedef enum logic [1:0] {
    FAS_DOOR_IDLE  = 2'b00,
    FAS_DOOR_DWELL = 2'b01,
    FAS_DOOR_CLOSE = 2'b10
  } fas_door_e;

  typedef struct packed {
    logic hall_stop;
    logic car_call;
    logic reopen;
    logic doors_open;
    logic doors_closed;
  } fas_door_s;

  typedef struct packed {
    logic automatic_mode;
    logic call_registered;
    logic running_up;
    logic run_start;
    logic floor_passed;
    logic eye_input;
    logic inspection;
    logic top_reset;
    logic fire_main;
    logic fire_alt;
    logic idle;
    logic homing_en;
    logic alt_home_en;
  } fas_car_s;

endpackage : fas_pkg

//--- hdl/fas_bank.sv
// Field-adjust settings bank with the timers and landings it drives.
// Assumes pins come from input modules, asynchronous to clk_sys.
`timescale 1ns/1ps
`default_nettype none
`include "fas_defs.svh"

module fas_bank
  import fas_pkg::*;
#(
  parameter int unsigned TENTH_CYCLES = `FAS_TENTH_CYCLES
) (
  input  wire logic        clk_sys,
  input  wire logic        rst_b,
  input  wire logic [6:0]  select_input,
  input  wire logic        commit_strobe_input,
  input  wire logic [15:0] value_input,
  input  wire fas_door_s   door_pin,
  input  wire fas_car_s    car_pin,
  input  wire logic [7:0]  car_floor,
  output logic             adjust_mode,
  output logic             door_close_cmd,
  output logic             nudge_cmd,
  output logic             eye_ignored,
  output logic             run_shutdown,
  output logic             own_landing_calls_off,
  output logic [15:0]      load_position,
  output logic [15:0]      target_floor,
  output logic             target_valid,
  output logic             fire_doors_hold,
  output logic [15:0]      top_served_floor,
  output logic [15:0]      read_value
);

  // ----------------------------------------
  // Input synchronisers
  // ----------------------------------------
  localparam int SYNC_W = 7 + 1 + 16 + 5 + 13;
  logic [SYNC_W-1:0] sync_a;
  logic [SYNC_W-1:0] sync_b;

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      sync_a <= '0;
      sync_b <= '0;
    end else begin
      sync_a <= {select_input, commit_strobe_input, value_input, door_pin, car_pin};
      sync_b <= sync_a;
    end
  end

  logic [6:0]  sel;
  logic        commit;
  logic [15:0] val;
  fas_door_s   door;
  fas_car_s    car;
  assign {sel, commit, val, door, car} = sync_b;

  // ----------------------------------------
  // Power-up straps, taken on third edge once synchroniser is full
  // ----------------------------------------
  logic [1:0] strap_cnt;
  logic       factory_req;
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      strap_cnt   <= 2'h0;
      adjust_mode <= 1'b0;
      factory_req <= 1'b0;
    end else if (strap_cnt != 2'h3) begin
      strap_cnt   <= strap_cnt + 2'h1;
      adjust_mode <= val[0] & val[1];
      factory_req <= (strap_cnt == 2'h2) & val[0] & val[1] & ~val[2];
    end else begin
      factory_req <= 1'b0;
    end
  end

  // Strap inputs must drop before selections count
  logic armed;
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      armed <= 1'b0;
    end else if (adjust_mode && strap_cnt == 2'h3 && !val[0] && !val[1]) begin
      armed <= 1'b1;
    end
  end

  // ----------------------------------------
  // Register file 51..99
  // ----------------------------------------
  localparam int NREG = 49;
  logic [15:0] regs [NREG];

  function automatic logic [15:0] fas_default(input logic [6:0] num);
    case (num)
      `FAS_HALL_DWELL:    fas_default = `FAS_DEF_HALL_DWELL;
      `FAS_CAR_DWELL:     fas_default = `FAS_DEF_CAR_DWELL;
      `FAS_SHORT_DWELL:   fas_default = `FAS_DEF_SHORT_DWELL;
      `FAS_RUN_SHUTDOWN:  fas_default = `FAS_DEF_RUN_SHUTDOWN;
      `FAS_NUDGING:       fas_default = `FAS_DEF_NUDGING;
      `FAS_EYE_CUTOUT:    fas_default = `FAS_DEF_EYE_CUTOUT;
      `FAS_STUCK_BUTTON:  fas_default = `FAS_DEF_STUCK_BUTTON;
      `FAS_LANDING_COUNT: fas_default = `FAS_DEF_LANDINGS;
      `FAS_MAIN_FIRE:     fas_default = `FAS_DEF_MAIN_FIRE;
      `FAS_ALT_FIRE:      fas_default = `FAS_DEF_ALT_FIRE;
      `FAS_ALT_HOME:      fas_default = `FAS_DEF_ALT_HOME;
      default:            fas_default = `FAS_DEF_OTHER;
    endcase
  endfunction : fas_default

  function automatic logic in_range(input logic [6:0] num);
    in_range = (num >= `FAS_REG_FIRST) && (num <= `FAS_REG_LAST);
  endfunction : in_range

  logic commit_d;
  logic write_en;
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      commit_d <= 1'b0;
    end else begin
      commit_d <= commit;
    end
  end
  assign write_en = adjust_mode && armed && commit && !commit_d && in_range(sel);

  logic [5:0] widx;
  assign widx = 6'(sel - `FAS_REG_FIRST);

  // Value inputs are two's complement weights directly
  genvar gi;
  generate
    for (gi = 0; gi < NREG; gi++) begin : g_reg
      localparam logic [6:0] NUM = 7'(gi + 51);
      // Settings survive reset; only the factory strap reloads them
      always_ff @(posedge clk_sys) begin
        if (factory_req) begin
          regs[gi] <= fas_default(NUM);
        end else if (write_en && widx == 6'(gi)) begin
          regs[gi] <= val;
        end
      end
    end
  endgenerate

  function automatic logic [15:0] rd(input logic [6:0] num);
    rd = regs[6'(num - `FAS_REG_FIRST)];
  endfunction : rd

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      read_value <= '0;
    end else begin
      read_value <= in_range(sel) ? rd(sel) : 16'h0000;
    end
  end

  // ----------------------------------------
  // Tenth-second tick
  // ----------------------------------------
  logic [31:0] pre_cnt;
  logic        tick;
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      pre_cnt <= '0;
    end else if (pre_cnt >= TENTH_CYCLES - 1) begin
      pre_cnt <= '0;
    end else begin
      pre_cnt <= pre_cnt + 32'h1;
    end
  end
  assign tick = (pre_cnt >= TENTH_CYCLES - 1);

  // ----------------------------------------
  // Door dwell
  // ----------------------------------------
  fas_door_e   door_state;
  logic [15:0] dwell_left;
  logic        hall_dwell;
  logic        car_d;
  logic        car_new;
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      car_d <= 1'b0;
    end else begin
      car_d <= door.car_call;
    end
  end
  assign car_new = door.car_call && !car_d;

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      door_state <= FAS_DOOR_IDLE;
      dwell_left <= '0;
      hall_dwell <= 1'b0;
    end else begin
      case (door_state)
        FAS_DOOR_IDLE: begin
          if (door.doors_open) begin
            door_state <= FAS_DOOR_DWELL;
            hall_dwell <= door.hall_stop;
            if (door.hall_stop) begin
              dwell_left <= rd(`FAS_HALL_DWELL);
            end else if (door.reopen) begin
              dwell_left <= rd(`FAS_SHORT_DWELL);
            end else begin
              dwell_left <= rd(`FAS_CAR_DWELL);
            end
          end
        end
        FAS_DOOR_DWELL: begin
          if (car_new && hall_dwell && dwell_left > rd(`FAS_CAR_DWELL)) begin
            dwell_left <= rd(`FAS_CAR_DWELL);
            hall_dwell <= 1'b0;
          end else if (car_new && !hall_dwell && dwell_left > rd(`FAS_SHORT_DWELL)) begin
            dwell_left <= rd(`FAS_SHORT_DWELL);
          end else if (dwell_left == 16'h0) begin
            door_state <= FAS_DOOR_CLOSE;
          end else if (tick) begin
            dwell_left <= dwell_left - 16'h1;
          end
        end
        FAS_DOOR_CLOSE: begin
          if (door.doors_closed) begin
            door_state <= FAS_DOOR_IDLE;
          end
        end
        default: door_state <= FAS_DOOR_IDLE;
      endcase
    end
  end
  assign door_close_cmd = (door_state == FAS_DOOR_CLOSE);

  // ----------------------------------------
  // Nudging, seconds counted in tenths to avoid a whole-second error
  // ----------------------------------------
  logic [19:0] nudge_cnt;
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      nudge_cnt <= '0;
      nudge_cmd <= 1'b0;
    end else if (door.doors_closed || car.run_start || !car.automatic_mode || !car.call_registered) begin
      nudge_cnt <= '0;
      nudge_cmd <= 1'b0;
    end else if (nudge_cnt >= 20'(rd(`FAS_NUDGING)) * 20'(`FAS_TENTHS_PER_SEC)) begin
      nudge_cmd <= 1'b1;
    end else if (tick) begin
      nudge_cnt <= nudge_cnt + 20'h1;
    end
  end

  // ----------------------------------------
  // Electric eye cutout, seconds
  // ----------------------------------------
  logic [19:0] eye_cnt;
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      eye_cnt     <= '0;
      eye_ignored <= 1'b0;
    end else if (car.floor_passed || car.run_start) begin
      eye_cnt     <= '0;
      eye_ignored <= 1'b0;
    end else if (eye_ignored) begin
      eye_ignored <= 1'b1;
    end else if (!car.eye_input) begin
      eye_cnt <= '0;
    end else if (eye_cnt >= 20'(rd(`FAS_EYE_CUTOUT)) * 20'(`FAS_TENTHS_PER_SEC)) begin
      eye_ignored <= 1'b1;
    end else if (tick) begin
      eye_cnt <= eye_cnt + 20'h1;
    end
  end

  // ----------------------------------------
  // Run-without-floor shutdown, tenths
  // ----------------------------------------
  logic [15:0] run_cnt;
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      run_cnt      <= '0;
      run_shutdown <= 1'b0;
    end else if (car.inspection) begin
      run_cnt      <= '0;
      run_shutdown <= 1'b0;
    end else if (!car.running_up || car.floor_passed) begin
      run_cnt <= '0;
    end else if (run_cnt >= rd(`FAS_RUN_SHUTDOWN)) begin
      run_shutdown <= 1'b1;
    end else if (tick) begin
      run_cnt <= run_cnt + 16'h1;
    end
  end

  // ----------------------------------------
  // Stuck button, seconds
  // ----------------------------------------
  logic [19:0] stuck_cnt;
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      stuck_cnt             <= '0;
      own_landing_calls_off <= 1'b0;
    end else if (car.run_start || !door.doors_open) begin
      stuck_cnt             <= '0;
      own_landing_calls_off <= 1'b0;
    end else if (stuck_cnt >= 20'(rd(`FAS_STUCK_BUTTON)) * 20'(`FAS_TENTHS_PER_SEC)) begin
      own_landing_calls_off <= 1'b1;
    end else if (tick) begin
      stuck_cnt <= stuck_cnt + 20'h1;
    end
  end

  // ----------------------------------------
  // Landings, fire and homing
  // ----------------------------------------
  logic [15:0] landings;
  logic [15:0] fire_sel;
  logic        fire_over;
  assign landings  = rd(`FAS_LANDING_COUNT);
  assign fire_sel  = car.fire_main ? rd(`FAS_MAIN_FIRE) : rd(`FAS_ALT_FIRE);
  assign fire_over = $signed(fire_sel) > $signed(landings);

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      top_served_floor <= '0;
      load_position    <= '0;
      target_floor     <= '0;
      target_valid     <= 1'b0;
      fire_doors_hold  <= 1'b0;
    end else begin
      top_served_floor <= landings;
      load_position    <= car.top_reset ? landings : {8'h00, car_floor};
      fire_doors_hold  <= (car.fire_main || car.fire_alt) && fire_over;
      if (car.fire_main || car.fire_alt) begin
        target_floor <= fire_over ? landings : fire_sel;
        target_valid <= 1'b1;
      end else if (car.idle && car.alt_home_en) begin
        target_floor <= rd(`FAS_ALT_HOME);
        target_valid <= 1'b1;
      end else if (car.idle && car.homing_en) begin
        target_floor <= rd(`FAS_MAIN_FIRE);
        target_valid <= 1'b1;
      end else begin
        target_valid <= 1'b0;
      end
    end
  end

endmodule : fas_bank
`default_nettype wire

//--- testbench/fas_bank_monitor.sv
// Port checker for the settings bank.
// Assumes a bind onto fas_bank with one clock domain.
`timescale 1ns/1ps
`default_nettype none
module fas_bank_monitor
  import fas_pkg::*;
(
  input wire logic        clk_sys,
  input wire logic        rst_b,
  input wire logic [6:0]  select_input,
  input wire logic        commit_strobe_input,
  input wire fas_door_s   door_pin,
  input wire fas_car_s    car_pin,
  input wire logic        adjust_mode,
  input wire logic        door_close_cmd,
  input wire logic        nudge_cmd,
  input wire logic        eye_ignored,
  input wire logic        run_shutdown,
  input wire logic [15:0] load_position,
  input wire logic [15:0] target_floor,
  input wire logic        fire_doors_hold,
  input wire logic [15:0] top_served_floor,
  input wire logic [15:0] read_value
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_b);
  // ----------------------------------------
  // Sequences
  // ----------------------------------------
  sequence sel_outside;
    (select_input < 7'h33 || select_input > 7'h63)[*4];
  endsequence
  sequence pins_quiet;
    ($stable(select_input) && $stable(commit_strobe_input))[*6];
  endsequence
  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  a_outside_reads_zero: assert property (sel_outside |=> read_value == 16'h0000)
    else $error("unmapped register read not zero");
  a_read_steady: assert property (pins_quiet |=> $stable(read_value))
    else $error("register changed without commit edge");
  a_mode_steady: assert property (adjust_mode |=> adjust_mode)
    else $error("adjust mode dropped");
  a_load_on_top: assert property (car_pin.top_reset[*4] |=> load_position == top_served_floor)
    else $error("top reset position not landing count");
  a_fire_hold_top: assert property (fire_doors_hold |-> target_floor == top_served_floor)
    else $error("doors held but target not top landing");
  a_shutdown_holds: assert property (run_shutdown && !car_pin.inspection |=> run_shutdown)
    else $error("shutdown cleared without inspection");
  a_eye_after_input: assert property ($rose(eye_ignored) |-> $past(car_pin.eye_input, 3))
    else $error("eye cut out without eye input");
  a_close_after_open: assert property ($rose(door_close_cmd) |-> $past(door_pin.doors_open, 3))
    else $error("close began without doors open");
  a_nudge_needs_call: assert property ($rose(nudge_cmd) |-> $past(car_pin.call_registered, 3) &&
                                       $past(car_pin.automatic_mode, 3))
    else $error("nudging without call in automatic");
endmodule : fas_bank_monitor
`default_nettype wire

//--- testbench/fas_tech_model.sv
// Technician jumpering select, value and commit pins.
// Assumes tasks are called from the bench; pins change at falling edge.
`timescale 1ns/1ps
`default_nettype none
module fas_tech_model (
  input  wire logic   clk_sys,
  output logic [6:0]  select_input,
  output logic        commit_strobe_input,
  output logic [15:0] value_input
);
  // Power-up straps: two lowest on, third off
  initial begin
    select_input        = 7'h00;
    commit_strobe_input = 1'b0;
    value_input         = 16'h0003;
  end
  task automatic set_pins(input logic [6:0] r, input logic [15:0] v);
    @(negedge clk_sys);
    select_input = r;
    value_input  = v;
    repeat (4) @(negedge clk_sys);
  endtask : set_pins
  task automatic commit(input logic b, input int n);
    commit_strobe_input = b;
    repeat (n) @(negedge clk_sys);
  endtask : commit
endmodule : fas_tech_model
`default_nettype wire

//--- testbench/fas_bank_tb.sv
// Self-checking bench for the settings bank.
// Assumes design files and fas_defs.svh on the include path.
`timescale 1ns/1ps
`default_nettype none
`include "fas_defs.svh"
module fas_bank_tb
  import fas_pkg::*;
;
  logic        clk_sys, rst_b, commit_strobe_input, adjust_mode, door_close_cmd, nudge_cmd;
  logic        eye_ignored, run_shutdown, own_landing_calls_off, target_valid, fire_doors_hold;
  logic [6:0]  select_input;
  logic [7:0]  car_floor;
  logic [15:0] value_input, load_position, target_floor, top_served_floor, read_value;
  fas_door_s   door_pin;
  fas_car_s    car_pin;
  int          mismatches, comparisons, mdl[int], s;
  bit          armed;
  logic [6:0]  regs[$] = '{7'h41, 7'h42, 7'h43, 7'h44, 7'h45, 7'h46, 7'h47, 7'h4c, 7'h4d, 7'h4e, 7'h55};
  int          defs[$] = '{50, 50, 10, 250, 25, 20, 30, 8, 1, 2, 1};
  int          tenths[$] = '{10, 6, 3};
  int          vals[$] = '{5, 1, 1, 1, 6, 2, 9, 4};

  fas_bank #(.TENTH_CYCLES(4)) i_fas_bank (.clk_sys, .rst_b, .select_input, .commit_strobe_input,
    .value_input, .door_pin, .car_pin, .car_floor, .adjust_mode, .door_close_cmd, .nudge_cmd,
    .eye_ignored, .run_shutdown, .own_landing_calls_off, .load_position, .target_floor,
    .target_valid, .fire_doors_hold, .top_served_floor, .read_value);
  fas_tech_model i_fas_tech_model (.clk_sys, .select_input, .commit_strobe_input, .value_input);

  initial begin
    clk_sys = 1'b0;
    forever #2 clk_sys = ~clk_sys;
  end

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    comparisons++;
    if (got !== exp) begin
      mismatches++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic rd(input logic [6:0] r);
    i_fas_tech_model.set_pins(r, 16'h0000);
    chk(read_value, mdl.exists(r) ? 16'(mdl[r]) : 16'h0000);
  endtask : rd
  task automatic wr(input logic [6:0] r, input logic [15:0] v);
    i_fas_tech_model.set_pins(r, v);
    i_fas_tech_model.commit(1'b1, 3);
    i_fas_tech_model.commit(1'b0, 4);
    s = 0;
    for (int i = 0; i < 16; i++) if (v[i]) s += (i == 15) ? -32768 : (1 << i);
    if (armed && r >= 7'h33 && r <= 7'h63) mdl[r] = s;
  endtask : wr
  // Power cycle with the given straps on the value pins
  task automatic restart(input logic [15:0] straps);
    i_fas_tech_model.set_pins(7'h00, straps);
    rst_b = 1'b0;
    repeat (3) @(negedge clk_sys);
    rst_b = 1'b1;
    repeat (3) @(negedge clk_sys);
    chk(16'(adjust_mode), 16'h0001);
  endtask : restart
  function automatic logic pick(input int k);
    case (k)
      0: return door_close_cmd;
      1: return run_shutdown;
      2: return nudge_cmd;
      3: return eye_ignored;
      default: return own_landing_calls_off;
    endcase
  endfunction : pick
  // Output k must rise after lo and by hi cycles
  task automatic tmr(input int k, input int lo, input int hi);
    int n;
    n = 0;
    while (pick(k) !== 1'b1 && n < hi) begin
      @(negedge clk_sys);
      n++;
    end
    comparisons++;
    if (pick(k) !== 1'b1 || n < lo) begin
      mismatches++;
      $display("Error at %0t: timer %0d after %0d cycles", $time, k, n);
    end
  endtask : tmr
  task automatic end_sim();
    $display("Comparisons %0d, mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : end_sim

  initial begin
    #60000;
    mismatches++;
    $display("Error at %0t: watchdog expired", $time);
    end_sim();
  end

  initial begin
    rst_b = 1'b0;
    door_pin = '0;
    door_pin.doors_closed = 1'b1;
    car_pin = '0;
    car_floor = 8'h03;
    void'($urandom(77));
    foreach (regs[i]) mdl[regs[i]] = defs[i];
    repeat (3) @(negedge clk_sys);
    rst_b = 1'b1;
    repeat (3) @(negedge clk_sys);
    chk(16'(adjust_mode), 16'h0001);
    wr(7'h41, 16'h0003);
    armed = 1'b1;
    foreach (regs[i]) rd(regs[i]);
    for (int i = 0; i < 8; i++) begin
      s = (i == 0) ? 'h33 : (i == 1) ? 'h63 : (i == 2) ? 'h32 : (i == 3) ? 'h64 : 'h33 + $urandom % 49;
      wr(7'(s), 16'($urandom));
      rd(7'(s));
    end
    wr(7'h50, 16'h8001);
    rd(7'h50);
    i_fas_tech_model.set_pins(7'h51, 16'h1234);
    i_fas_tech_model.commit(1'b1, 3);
    i_fas_tech_model.set_pins(7'h51, 16'h4321);
    i_fas_tech_model.commit(1'b0, 4);
    mdl['h51] = 'h1234;
    rd(7'h51);
    restart(16'h0007);
    foreach (regs[i]) rd(regs[i]);
    rd(7'h51);
    restart(16'h0003);
    mdl.delete();
    foreach (regs[i]) mdl[regs[i]] = defs[i];
    foreach (regs[i]) rd(regs[i]);
    rd(7'h51);
    foreach (regs[i]) wr(regs[i], 16'((i < 3) ? tenths[i] : vals[i - 3]));
    foreach (tenths[k]) begin
      door_pin = '0;
      door_pin.hall_stop = (k == 0);
      door_pin.reopen = (k == 2);
      door_pin.doors_open = 1'b1;
      tmr(0, tenths[k] * 4 - 4, tenths[k] * 4 + 8);
      door_pin = '0;
      door_pin.doors_closed = 1'b1;
      repeat (8) @(negedge clk_sys);
    end
    door_pin = '0;
    door_pin.hall_stop = 1'b1;
    door_pin.doors_open = 1'b1;
    repeat (8) @(negedge clk_sys);
    door_pin.car_call = 1'b1;
    tmr(0, 20, 30);
    door_pin.hall_stop = 1'b0;
    door_pin.car_call = 1'b0;
    car_pin.automatic_mode = 1'b1;
    car_pin.call_registered = 1'b1;
    tmr(2, 36, 52);
    tmr(4, 0, 52);
    door_pin.doors_open = 1'b0;
    door_pin.doors_closed = 1'b1;
    repeat (6) @(negedge clk_sys);
    chk(16'(nudge_cmd), 16'h0000);
    car_pin.eye_input = 1'b1;
    tmr(3, 36, 52);
    car_pin.eye_input = 1'b0;
    car_pin.floor_passed = 1'b1;
    repeat (6) @(negedge clk_sys);
    chk(16'(eye_ignored), 16'h0000);
    car_pin.floor_passed = 1'b0;
    car_pin.running_up = 1'b1;
    tmr(1, 16, 28);
    car_pin.running_up = 1'b0;
    car_pin.inspection = 1'b1;
    repeat (6) @(negedge clk_sys);
    chk(16'(run_shutdown), 16'h0000);
    car_pin = '0;
    car_pin.top_reset = 1'b1;
    repeat (6) @(negedge clk_sys);
    chk(top_served_floor, 16'h0006);
    chk(load_position, 16'h0006);
    car_pin = '0;
    car_pin.fire_main = 1'b1;
    repeat (6) @(negedge clk_sys);
    chk({target_floor[14:0], target_valid}, 16'h0005);
    chk(load_position, 16'h0003);
    car_pin = '0;
    car_pin.fire_alt = 1'b1;
    repeat (6) @(negedge clk_sys);
    chk({target_floor[14:0], fire_doors_hold}, 16'h000d);
    car_pin = '0;
    car_pin.idle = 1'b1;
    car_pin.homing_en = 1'b1;
    repeat (6) @(negedge clk_sys);
    chk(target_floor, 16'h0002);
    car_pin.alt_home_en = 1'b1;
    repeat (6) @(negedge clk_sys);
    chk(target_floor, 16'h0004);
    end_sim();
  end
endmodule : fas_bank_tb

bind fas_bank fas_bank_monitor i_fas_bank_monitor (.clk_sys, .rst_b, .select_input, .commit_strobe_input,
  .door_pin, .car_pin, .adjust_mode, .door_close_cmd, .nudge_cmd, .eye_ignored, .run_shutdown,
  .load_position, .target_floor, .fire_doors_hold, .top_served_floor, .read_value);
`default_nettype wire
